/* File: src/odsm_pkg.sv */
// Constants shared by the output divider and switch matrix block
package odsm_pkg;
  localparam int NUM_DIV = 6;
  localparam int NUM_OUT = 6;
  localparam int NUM_PLL = 4;
  localparam logic [7:0] REG_INPUT_SOURCE = 8'h0b;
  localparam logic [7:0] REG_POWER_DOWN = 8'h0c;
  localparam logic [7:0] REG_CONTROL = 8'h0a;
  localparam logic [7:0] REG_DIV_BASE = 8'h0d;
  localparam logic [7:0] REG_DIV_LAST = 8'h12;
  localparam logic [7:0] REG_OUT_BASE = 8'h13;
  localparam logic [7:0] REG_OUT_LAST = 8'h18;
  localparam logic [7:0] REG_DSRC_BASE = 8'h09;
  // Field positions
  localparam int SRC_TYPE_HI = 7;
  localparam int SRC_TYPE_LO = 6;
  localparam int PD_BIT = 6;
  localparam int CLK_SEL_BIT = 4;
  localparam int CTLB_CFG_HI = 3;
  localparam int CTLB_CFG_LO = 2;
  localparam int CTLA_CFG_HI = 1;
  localparam int CTLA_CFG_LO = 0;
  localparam int ENABLE_BIT = 3;
  localparam int INVERT_BIT = 6;
  localparam int RATIO_W = 7;
  localparam int ROUTE_W = 3;
  // Source type codes
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'h0,
    SRC_SINGLE = 2'h1,
    SRC_DIFF = 2'h2,
    SRC_RESERVED = 2'h3
  } odsm_src_t;
  // Control input B behaviour
  localparam logic [1:0] CTLB_LOW = 2'h0;
  localparam logic [1:0] CTLB_HIZ = 2'h1;
  // Divider source codes
  localparam logic [2:0] DSRC_BYPASS = 3'h0;
  localparam logic [2:0] DSRC_PLL1 = 3'h1;
  localparam logic [2:0] DSRC_PLL2 = 3'h2;
  localparam logic [2:0] DSRC_PLL2_SSC = 3'h3;
  localparam logic [2:0] DSRC_PLL3 = 3'h4;
  // Reset values
  localparam logic [7:0] RST_INPUT_SOURCE = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUT_CFG = 8'h3a;
  // Even divider in [6:4], odd divider in [2:0]: P0 from PLL2, P1 from PLL3, P2..P5 from PLL1
  localparam logic [7:0] RST_DSRC_01 = 8'h24;
  localparam logic [7:0] RST_DSRC_23 = 8'h11;
  localparam logic [7:0] RST_DSRC_45 = 8'h11;
  localparam logic [6:0] RST_RATIO [NUM_DIV] = '{7'h0a, 7'h14, 7'h08, 7'h09, 7'h20, 7'h04};
  localparam logic [2:0] ROUTE_DEFAULT = 3'h2;
  localparam logic [2:0] ROUTE_MAX = 3'h5;
  localparam logic [6:0] RATIO_ONE = 7'h01;
endpackage

/* File: src/odsm_divider.sv */
// Single post-divider: counter cleared to zero once it reaches its ratio minus one
`timescale 1ns/1ps
module odsm_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_in,
  input wire logic [6:0] ratio,
  input wire logic run,
  output logic div_out
);
  logic [6:0] cnt_q;
  logic src_q;
  logic tog_q;
  logic rise;
  assign rise = src_in & ~src_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_in;
    end
  end

  // Counts source rising edges; output toggles across the ratio
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_q <= 7'h00;
      tog_q <= 1'b0;
    end else if (rise) begin
      if (cnt_q >= ratio - odsm_pkg::RATIO_ONE) begin
        cnt_q <= 7'h00;
        tog_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + odsm_pkg::RATIO_ONE;
        if (cnt_q >= (ratio >> 1) - odsm_pkg::RATIO_ONE) begin
          tog_q <= 1'b0;
        end
      end
    end
  end

  // Divide by one passes the source straight through
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      div_out <= 1'b0;
    end else if (ratio == odsm_pkg::RATIO_ONE) begin
      div_out <= src_in;
    end else begin
      div_out <= tog_q;
    end
  end
endmodule

/* File: src/odsm_top.sv */
// Output divider and switch matrix of the clock synthesizer
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Source type 00 makes pin A the crystal input and pin B the crystal drive, and is the default.
// - Source type 01 treats both pins as single-ended and passes the one chosen by the clock select.
// - Source type 10 uses both pins as one differential input; code 11 is reserved.
// - The stored clock select bit is ignored for crystal or differential source types.
// - Bit 6 of the power-down byte selects normal operation at 0 (default) and power-down at 1.
// - Power-down stops the PLLs and input stage, floats all outputs, keeps registers and bus access.
// - Power-down wins over any float or force-low state asked by the control inputs.
// - Each of six post-dividers divides by its 7-bit ratio 1..127, reset ratios 10,20,8,9,32,4.
// - Each output's 3-bit selector routes post-divider 0..5; codes 110 and 111 are reserved.
// - After reset every output selector picks post-divider 2.
// - Each post-divider's source is bypass, PLL1, PLL2, PLL2 with spread, or PLL3.
// - Control input B low forces all outputs inactive (config 00) or floating (config 01); configs 10 and 11 leave them running.
module odsm_top (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic CLOCK_PIN_A,
  input wire logic CLOCK_PIN_B,
  input wire logic CONTROL_INPUT_A,
  input wire logic CONTROL_INPUT_B,
  input wire logic [2:0] PLL_CLOCKS,
  input wire logic PLL2_SSC_CLOCK,
  output logic CRYSTAL_DRIVE,
  output logic INPUT_STAGE_RUN,
  output logic PLL_RUN,
  output logic [5:0] CLOCK_OUTPUTS,
  output logic [5:0] CLOCK_OUTPUTS_OE
);
  logic [7:0] input_source_q;
  logic [7:0] power_down_q;
  logic [7:0] control_q;
  logic [7:0] dsrc_q [3];
  logic [6:0] ratio_q [odsm_pkg::NUM_DIV];
  logic [7:0] out_cfg_q [odsm_pkg::NUM_OUT];
  logic [1:0] pin_a_s;
  logic [1:0] pin_b_s;
  logic [1:0] ctla_s;
  logic [1:0] ctlb_s;
  logic [1:0] pll_s [4];
  logic ref_clk;
  logic pd;
  logic [5:0] div_clk;
  logic [5:0] div_src;
  logic [5:0] routed;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [2:0] dsrc_field(input int i, input logic [7:0] b0, input logic [7:0] b1,
                                             input logic [7:0] b2);
    logic [7:0] b;
    b = (i < 2) ? b0 : ((i < 4) ? b1 : b2);
    dsrc_field = (i % 2 == 0) ? b[6:4] : b[2:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      pin_a_s <= 2'h0;
      pin_b_s <= 2'h0;
      ctla_s <= 2'h3;
      ctlb_s <= 2'h3;
    end else begin
      pin_a_s <= {pin_a_s[0], CLOCK_PIN_A};
      pin_b_s <= {pin_b_s[0], CLOCK_PIN_B};
      ctla_s <= {ctla_s[0], CONTROL_INPUT_A};
      ctlb_s <= {ctlb_s[0], CONTROL_INPUT_B};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      for (int i = 0; i < 3; i++) begin
        pll_s[i] <= 2'h0;
      end
      pll_s[3] <= 2'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pll_s[i] <= {pll_s[i][0], PLL_CLOCKS[i]};
      end
      pll_s[3] <= {pll_s[3][0], PLL2_SSC_CLOCK};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file; contents survive power-down and stay writable
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      input_source_q <= odsm_pkg::RST_INPUT_SOURCE;
      power_down_q <= odsm_pkg::RST_POWER_DOWN;
      control_q <= odsm_pkg::RST_CONTROL;
    end else if (REG_WE) begin
      if (REG_ADDR == odsm_pkg::REG_INPUT_SOURCE) begin
        input_source_q <= REG_WDATA;
      end
      if (REG_ADDR == odsm_pkg::REG_POWER_DOWN) begin
        power_down_q <= REG_WDATA;
      end
      if (REG_ADDR == odsm_pkg::REG_CONTROL) begin
        control_q <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      dsrc_q[0] <= odsm_pkg::RST_DSRC_01;
      dsrc_q[1] <= odsm_pkg::RST_DSRC_23;
      dsrc_q[2] <= odsm_pkg::RST_DSRC_45;
    end else if (REG_WE && in_range(REG_ADDR, odsm_pkg::REG_DSRC_BASE, odsm_pkg::REG_DSRC_BASE + 8'h02)) begin
      dsrc_q[REG_ADDR[1:0] - odsm_pkg::REG_DSRC_BASE[1:0]] <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      for (int i = 0; i < odsm_pkg::NUM_DIV; i++) begin
        ratio_q[i] <= odsm_pkg::RST_RATIO[i];
      end
    end else if (REG_WE && in_range(REG_ADDR, odsm_pkg::REG_DIV_BASE, odsm_pkg::REG_DIV_LAST)) begin
      ratio_q[3'(REG_ADDR - odsm_pkg::REG_DIV_BASE)] <= REG_WDATA[6:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      for (int i = 0; i < odsm_pkg::NUM_OUT; i++) begin
        out_cfg_q[i] <= odsm_pkg::RST_OUT_CFG;
      end
    end else if (REG_WE && in_range(REG_ADDR, odsm_pkg::REG_OUT_BASE, odsm_pkg::REG_OUT_LAST)) begin
      out_cfg_q[3'(REG_ADDR - odsm_pkg::REG_OUT_BASE)] <= REG_WDATA;
    end
  end

  // Read back; unmapped bytes read zero
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_ADDR == odsm_pkg::REG_INPUT_SOURCE) begin
      REG_RDATA <= input_source_q;
    end else if (REG_ADDR == odsm_pkg::REG_POWER_DOWN) begin
      REG_RDATA <= power_down_q;
    end else if (REG_ADDR == odsm_pkg::REG_CONTROL) begin
      REG_RDATA <= control_q;
    end else if (in_range(REG_ADDR, odsm_pkg::REG_DSRC_BASE, odsm_pkg::REG_DSRC_BASE + 8'h02)) begin
      REG_RDATA <= dsrc_q[REG_ADDR[1:0] - odsm_pkg::REG_DSRC_BASE[1:0]];
    end else if (in_range(REG_ADDR, odsm_pkg::REG_DIV_BASE, odsm_pkg::REG_DIV_LAST)) begin
      REG_RDATA <= {1'b0, ratio_q[3'(REG_ADDR - odsm_pkg::REG_DIV_BASE)]};
    end else if (in_range(REG_ADDR, odsm_pkg::REG_OUT_BASE, odsm_pkg::REG_OUT_LAST)) begin
      REG_RDATA <= out_cfg_q[3'(REG_ADDR - odsm_pkg::REG_OUT_BASE)];
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input stage
  assign pd = power_down_q[odsm_pkg::PD_BIT];

  always_comb begin
    case (odsm_pkg::odsm_src_t'(input_source_q[odsm_pkg::SRC_TYPE_HI:odsm_pkg::SRC_TYPE_LO]))
      odsm_pkg::SRC_CRYSTAL: ref_clk = pin_a_s[1];
      odsm_pkg::SRC_SINGLE: ref_clk = control_q[odsm_pkg::CLK_SEL_BIT] ? pin_b_s[1] : pin_a_s[1];
      odsm_pkg::SRC_DIFF: ref_clk = pin_a_s[1] & ~pin_b_s[1];
      default: ref_clk = 1'b0;
    endcase
  end

  // Crystal drive is the inverted input only in crystal mode outside power-down, held low otherwise
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      CRYSTAL_DRIVE <= 1'b0;
      INPUT_STAGE_RUN <= 1'b0;
      PLL_RUN <= 1'b0;
    end else begin
      CRYSTAL_DRIVE <= !pd && input_source_q[odsm_pkg::SRC_TYPE_HI:odsm_pkg::SRC_TYPE_LO] == odsm_pkg::SRC_CRYSTAL
                       && !pin_a_s[1];
      INPUT_STAGE_RUN <= !pd;
      PLL_RUN <= !pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divider sources and post-dividers
  always_comb begin
    for (int i = 0; i < odsm_pkg::NUM_DIV; i++) begin
      case (dsrc_field(i, dsrc_q[0], dsrc_q[1], dsrc_q[2]))
        odsm_pkg::DSRC_BYPASS: div_src[i] = ref_clk;
        odsm_pkg::DSRC_PLL1: div_src[i] = pll_s[0][1];
        odsm_pkg::DSRC_PLL2: div_src[i] = pll_s[1][1];
        odsm_pkg::DSRC_PLL2_SSC: div_src[i] = pll_s[3][1];
        odsm_pkg::DSRC_PLL3: div_src[i] = pll_s[2][1];
        default: div_src[i] = 1'b0;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < odsm_pkg::NUM_DIV; g++) begin : gen_div
      odsm_divider u_div (
        .clk(CLOCK),
        .rst_n(RSTN),
        .src_in(div_src[g]),
        .ratio(ratio_q[g]),
        .run(!pd),
        .div_out(div_clk[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Output switch matrix and output control
  always_comb begin
    for (int i = 0; i < odsm_pkg::NUM_OUT; i++) begin
      if (out_cfg_q[i][2:0] <= odsm_pkg::ROUTE_MAX) begin
        routed[i] = div_clk[out_cfg_q[i][2:0]];
      end else begin
        routed[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      CLOCK_OUTPUTS <= 6'h00;
      CLOCK_OUTPUTS_OE <= 6'h00;
    end else begin
      for (int i = 0; i < odsm_pkg::NUM_OUT; i++) begin
        if (pd) begin
          CLOCK_OUTPUTS[i] <= 1'b0;
          CLOCK_OUTPUTS_OE[i] <= 1'b0;
        end else if (!ctlb_s[1] && control_q[odsm_pkg::CTLB_CFG_HI:odsm_pkg::CTLB_CFG_LO] == odsm_pkg::CTLB_HIZ) begin
          CLOCK_OUTPUTS[i] <= 1'b0;
          CLOCK_OUTPUTS_OE[i] <= 1'b0;
        end else if ((!ctlb_s[1] && control_q[odsm_pkg::CTLB_CFG_HI:odsm_pkg::CTLB_CFG_LO] == odsm_pkg::CTLB_LOW)
                     || !out_cfg_q[i][odsm_pkg::ENABLE_BIT]) begin
          CLOCK_OUTPUTS[i] <= out_cfg_q[i][odsm_pkg::INVERT_BIT];
          CLOCK_OUTPUTS_OE[i] <= 1'b1;
        end else begin
          CLOCK_OUTPUTS[i] <= routed[i] ^ out_cfg_q[i][odsm_pkg::INVERT_BIT];
          CLOCK_OUTPUTS_OE[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [1:0] src_type;
  logic [1:0] ctlb_cfg;
  assign src_type = input_source_q[odsm_pkg::SRC_TYPE_HI:odsm_pkg::SRC_TYPE_LO];
  assign ctlb_cfg = control_q[odsm_pkg::CTLB_CFG_HI:odsm_pkg::CTLB_CFG_LO];

  // Input stage
  AST_XTAL_IGNORE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (src_type == odsm_pkg::SRC_CRYSTAL) |-> ref_clk == pin_a_s[1])
    else $error("clock select not ignored in crystal mode");
  AST_SINGLE_SEL: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (src_type == odsm_pkg::SRC_SINGLE && control_q[odsm_pkg::CLK_SEL_BIT]) |-> ref_clk == pin_b_s[1])
    else $error("single-ended select wrong");
  AST_DIFF_SRC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (src_type == odsm_pkg::SRC_DIFF) |-> ref_clk == (pin_a_s[1] && !pin_b_s[1]))
    else $error("differential input not combined");
  AST_XTAL_DRIVE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && src_type == odsm_pkg::SRC_CRYSTAL) |=> CRYSTAL_DRIVE == !$past(pin_a_s[1]))
    else $error("crystal drive not the inverted input");
  AST_DRIVE_OFF: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (pd || src_type != odsm_pkg::SRC_CRYSTAL) |=> !CRYSTAL_DRIVE)
    else $error("crystal drive active outside crystal mode");

  // Power-down
  AST_PD_BIT: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (REG_WE && REG_ADDR == odsm_pkg::REG_POWER_DOWN && REG_WDATA[odsm_pkg::PD_BIT]) |=> ##1 !PLL_RUN)
    else $error("power-down bit not honoured");
  AST_RUN_ON: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !pd |=> (PLL_RUN && INPUT_STAGE_RUN))
    else $error("clock path stopped in normal operation");
  AST_PD_FLOAT: assert property (@(posedge CLOCK) disable iff (!RSTN)
    pd |=> (CLOCK_OUTPUTS_OE == 6'h00))
    else $error("outputs driven in power-down");
  AST_PD_RUN: assert property (@(posedge CLOCK) disable iff (!RSTN)
    pd |=> (!PLL_RUN && !INPUT_STAGE_RUN))
    else $error("PLL running in power-down");
  AST_DIV_STOP: assert property (@(posedge CLOCK) disable iff (!RSTN)
    pd |=> div_clk == 6'h00)
    else $error("post-divider running in power-down");
  AST_REGS_KEPT: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (pd && !REG_WE) |=> ($stable(input_source_q) && $stable(ratio_q[0]) && $stable(out_cfg_q[0])))
    else $error("register lost in power-down");
  AST_BUS_ALIVE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (pd && REG_ADDR == odsm_pkg::REG_POWER_DOWN) |=> REG_RDATA == $past(power_down_q))
    else $error("register read dead in power-down");
  AST_PD_PRIORITY: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (pd && !ctlb_s[1]) |=> (CLOCK_OUTPUTS_OE == 6'h00 && CLOCK_OUTPUTS == 6'h00))
    else $error("control input overrode power-down");

  // Register file and switch matrix
  AST_RATIO_RESET: assert property (@(posedge CLOCK)
    !RSTN |=> ratio_q[2] == odsm_pkg::RST_RATIO[2])
    else $error("divider ratio reset value wrong");
  AST_RATIO_WRITE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (REG_WE && REG_ADDR == odsm_pkg::REG_DIV_BASE)
    |=> ratio_q[0] == $past(REG_WDATA[odsm_pkg::RATIO_W - 1:0]))
    else $error("divider ratio not stored");
  AST_ROUTE_RESET: assert property (@(posedge CLOCK)
    !RSTN |=> out_cfg_q[5][odsm_pkg::ROUTE_W - 1:0] == odsm_pkg::ROUTE_DEFAULT)
    else $error("output selector reset value wrong");
  AST_ROUTE_WRITE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (REG_WE && REG_ADDR == odsm_pkg::REG_OUT_BASE) |=> out_cfg_q[0] == $past(REG_WDATA))
    else $error("output selector not stored");
  AST_ROUTE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && ctlb_s[1] && out_cfg_q[1][odsm_pkg::ENABLE_BIT]
     && out_cfg_q[1][odsm_pkg::ROUTE_W - 1:0] <= odsm_pkg::ROUTE_MAX)
    |=> CLOCK_OUTPUTS[1] == ($past(div_clk[out_cfg_q[1][odsm_pkg::ROUTE_W - 1:0]])
                             ^ $past(out_cfg_q[1][odsm_pkg::INVERT_BIT])))
    else $error("switch matrix routing wrong");

  // Divider sources and divide by one
  AST_BYPASS_SRC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (dsrc_field(0, dsrc_q[0], dsrc_q[1], dsrc_q[2]) == odsm_pkg::DSRC_BYPASS) |-> div_src[0] == ref_clk)
    else $error("bypass source not the input clock");
  AST_PLL3_SRC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (dsrc_field(1, dsrc_q[0], dsrc_q[1], dsrc_q[2]) == odsm_pkg::DSRC_PLL3) |-> div_src[1] == pll_s[2][1])
    else $error("PLL3 source not selected");
  AST_PLL1_SRC: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (dsrc_field(2, dsrc_q[0], dsrc_q[1], dsrc_q[2]) == odsm_pkg::DSRC_PLL1) |-> div_src[2] == pll_s[0][1])
    else $error("PLL1 source not selected");
  AST_DIV_ONE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && ratio_q[odsm_pkg::NUM_DIV - 1] == odsm_pkg::RATIO_ONE && $stable(ratio_q[odsm_pkg::NUM_DIV - 1]))
    |=> div_clk[odsm_pkg::NUM_DIV - 1] == $past(div_src[odsm_pkg::NUM_DIV - 1]))
    else $error("divide by one not a pass-through");

  // Control input B
  AST_CTLB_HIZ: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && !ctlb_s[1] && ctlb_cfg == odsm_pkg::CTLB_HIZ) |=> CLOCK_OUTPUTS_OE == 6'h00)
    else $error("outputs not floated by control input");
  AST_CTLB_LOW: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && !ctlb_s[1] && ctlb_cfg == odsm_pkg::CTLB_LOW && !out_cfg_q[0][odsm_pkg::INVERT_BIT])
    |=> (CLOCK_OUTPUTS[0] == 1'b0 && CLOCK_OUTPUTS_OE[0]))
    else $error("output not forced low");
  AST_OE_NORMAL: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!pd && ctlb_s[1]) |=> &CLOCK_OUTPUTS_OE)
    else $error("outputs floated without a request");
endmodule

/* File: test/odsm_host.sv */
// Host model that writes and reads configuration bytes
`timescale 1ns/1ps
module odsm_host (
  input wire logic CLOCK,
  output logic REG_WE,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);
  initial begin
    REG_WE = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
  end
  // Reserved and forbidden codes are never sent, whatever the caller asks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == odsm_pkg::REG_INPUT_SOURCE && d[7:6] == 2'h3) d[7:6] = 2'h0;
    if (a >= odsm_pkg::REG_DIV_BASE && a <= odsm_pkg::REG_DIV_LAST && d[6:0] == 7'h00) d[6:0] = 7'h01;
    if (a >= odsm_pkg::REG_OUT_BASE && a <= odsm_pkg::REG_OUT_LAST && d[2:0] > 3'h5) d[2:0] = 3'h5;
    @(posedge CLOCK);
    #1;
    REG_WE = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLOCK);
    #1;
    REG_WE = 1'b0;
    REG_WDATA = ~d;
  endtask
  // Read data is registered, so it is taken two edges after the address settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    #1;
    REG_ADDR = a;
    @(posedge CLOCK);
    @(posedge CLOCK);
    #1;
    d = REG_RDATA;
  endtask
endmodule

/* File: test/odsm_top_bench.sv */
// Self-checking bench for the output divider and switch matrix
`timescale 1ns/1ps
module odsm_top_bench;
  logic CLOCK, RSTN, REG_WE, CLOCK_PIN_A, CLOCK_PIN_B, CONTROL_INPUT_A, CONTROL_INPUT_B, PLL2_SSC_CLOCK;
  logic CRYSTAL_DRIVE, INPUT_STAGE_RUN, PLL_RUN;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [2:0] PLL_CLOCKS;
  logic [5:0] CLOCK_OUTPUTS, CLOCK_OUTPUTS_OE;
  int n_mismatch = 0;
  int num_checks = 0;
  int mdl [int];
  int ph = 0;
  logic pin_run = 1'b0;
  odsm_top odsm_top_i (.CLOCK(CLOCK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .CLOCK_PIN_A(CLOCK_PIN_A), .CLOCK_PIN_B(CLOCK_PIN_B),
    .CONTROL_INPUT_A(CONTROL_INPUT_A), .CONTROL_INPUT_B(CONTROL_INPUT_B), .PLL_CLOCKS(PLL_CLOCKS),
    .PLL2_SSC_CLOCK(PLL2_SSC_CLOCK), .CRYSTAL_DRIVE(CRYSTAL_DRIVE), .INPUT_STAGE_RUN(INPUT_STAGE_RUN),
    .PLL_RUN(PLL_RUN), .CLOCK_OUTPUTS(CLOCK_OUTPUTS), .CLOCK_OUTPUTS_OE(CLOCK_OUTPUTS_OE));
  odsm_host odsm_host_i (.CLOCK(CLOCK), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // All PLL clocks share a four-cycle period, so every PLL divider source gives the same base
  always @(posedge CLOCK) begin
    #1;
    ph++;
    PLL_CLOCKS = {3{ph[1]}};
    PLL2_SSC_CLOCK = ph[1];
    // Pin B carries an eight-cycle clock once the single-ended scenario starts
    if (pin_run) CLOCK_PIN_B = ph[2];
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input int a, input int d);
    odsm_host_i.wr(a[7:0], d[7:0]);
    mdl[a] = d;
  endtask
  task automatic rd_chk(input int a, input string msg);
    logic [7:0] d;
    odsm_host_i.rd(a[7:0], d);
    check(d, mdl.exists(a) ? mdl[a][7:0] : 8'h00, msg);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // Period between the second and third rising edge, so a reload glitch is skipped
  task automatic period(input int b, output int p);
    int n, t0, rises;
    logic prev;
    n = 0;
    t0 = 0;
    rises = 0;
    p = 0;
    prev = 1'b1;
    repeat (1000) begin
      @(posedge CLOCK);
      #1;
      n++;
      if (CLOCK_OUTPUTS[b] === 1'b1 && prev === 1'b0) begin
        rises++;
        if (rises == 3) begin
          p = n - t0;
          break;
        end
        t0 = n;
      end
      prev = CLOCK_OUTPUTS[b];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end
  initial begin
    int p;
    int r [6];
    RSTN = 1'b0;
    CLOCK_PIN_A = 1'b0;
    CLOCK_PIN_B = 1'b0;
    CONTROL_INPUT_A = 1'b1;
    CONTROL_INPUT_B = 1'b1;
    PLL_CLOCKS = 3'h0;
    PLL2_SSC_CLOCK = 1'b0;
    void'($urandom(90417));
    mdl[8'h0b] = odsm_pkg::RST_INPUT_SOURCE;
    mdl[8'h0c] = odsm_pkg::RST_POWER_DOWN;
    for (int k = 0; k < 6; k++) begin
      mdl[8'h0d + k] = odsm_pkg::RST_RATIO[k];
      mdl[8'h13 + k] = odsm_pkg::RST_OUT_CFG;
    end
    repeat (4) @(posedge CLOCK);
    #1;
    RSTN = 1'b1;
    for (int a = 8'h0b; a <= 8'h18; a++) rd_chk(a, "reset value");
    rd_chk(8'h40, "unmapped read");
    check(PLL_RUN, 1'b1, "run after reset");
    for (int k = 0; k < 6; k++) begin
      period(k, p);
      check(16'(p), 16'd32, "default route period");
    end
    // Cross routing with fresh ratios, ratio one on divider 5
    for (int k = 0; k < 6; k++) begin
      r[k] = (k == 5) ? 1 : $urandom_range(40, 2);
      wr(8'h0d + k, r[k]);
      rd_chk(8'h0d + k, "ratio readback");
      wr(8'h13 + k, 8'h38 | (5 - k));
    end
    for (int k = 0; k < 6; k++) begin
      period(k, p);
      check(16'(p), 16'(4 * r[5 - k]), "routed period");
    end
    // Power-down together with control input B low
    CONTROL_INPUT_B = 1'b0;
    wr(8'h0c, 8'h40);
    wait_n(4);
    check(PLL_RUN, 1'b0, "pll run in power-down");
    check(INPUT_STAGE_RUN, 1'b0, "input run in power-down");
    check(CLOCK_OUTPUTS_OE, 6'h00, "outputs float");
    check(CRYSTAL_DRIVE, 1'b0, "drive in power-down");
    rd_chk(8'h0e, "ratio kept in power-down");
    CONTROL_INPUT_B = 1'b1;
    wr(8'h0c, 8'h00);
    wait_n(4);
    check(PLL_RUN, 1'b1, "run restored");
    check(CLOCK_OUTPUTS_OE, 6'h3f, "outputs driven");
    // Crystal drive follows pin A inverted only in crystal mode
    CLOCK_PIN_A = 1'b1;
    wait_n(4);
    check(CRYSTAL_DRIVE, 1'b0, "drive with pin high");
    CLOCK_PIN_A = 1'b0;
    wait_n(4);
    check(CRYSTAL_DRIVE, 1'b1, "drive with pin low");
    wr(8'h0b, 8'h40);
    wait_n(4);
    check(CRYSTAL_DRIVE, 1'b0, "no drive single-ended");
    wr(8'h0b, 8'h80);
    wait_n(4);
    check(CRYSTAL_DRIVE, 1'b0, "no drive differential");
    rd_chk(8'h0b, "source type readback");
    wr(8'h0b, 8'h00);
    // Control input B low: forced low, then floating
    CONTROL_INPUT_B = 1'b0;
    wait_n(4);
    repeat (8) begin
      check(CLOCK_OUTPUTS, 6'h00, "forced low");
      check(CLOCK_OUTPUTS_OE, 6'h3f, "forced low driven");
      wait_n(1);
    end
    odsm_host_i.wr(odsm_pkg::REG_CONTROL, 8'h04);
    wait_n(4);
    check(CLOCK_OUTPUTS_OE, 6'h00, "forced float");
    // Pin B through the bypass source into divider 0, then crystal mode must ignore the select
    CONTROL_INPUT_B = 1'b1;
    pin_run = 1'b1;
    wr(8'h0a, 8'h10);
    wr(8'h09, 8'h02);
    wr(8'h0b, 8'h40);
    wr(8'h0d, 3);
    wr(8'h13, 8'h38);
    period(0, p);
    check(16'(p), 16'd24, "bypass pin B period");
    wr(8'h0b, 8'h00);
    period(0, p);
    check(16'(p), 16'd0, "select ignored in crystal mode");
    test_done();
  end
endmodule
